// ==== logic/sdhtx_overhead_regs.sv ====
`timescale 1ns/1ps
// Function
// - with processor control off, frame insertion advances the trace pointer
// - with processor control on, data register accesses advance pointer; 01H sent
// - trace pointer clears only on a 0 to 1 change of the clear bit
// - 8-bit read/write trace data register at 3BH maps to byte at pointer
// - r1c8 national byte from 31H when source is 00 and default disabled
// - r1c9 national byte from 32H when source is 00 and default disabled
// - r2c8 national byte from 33H when its source field is 00
// - r2c9 national byte from 34H when its source field is 00
// - r9c8 national byte from 35H when its source bit is 0
// - r9c9 national byte from 36H when its source bit is 0
// - K1 byte from 37H when its source bit is 0
// - K2 byte from 38H when source bit is 0 and defect source bit is 1
// - S1 byte from 39H when its source bit is 0
// - justification counters count only in add-drop mode; outside it they hold, but a capture write still clears them
// - 11-bit negative counter counts each negative justification
// - 11-bit positive counter counts each positive justification
// - write to negative capture copies counter to buffer and clears it
// - write to positive capture copies counter to buffer and clears it
module sdhtx_overhead_regs (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire sdhtx_pkg::sdhtx_axi_req_t axi_req,
	output sdhtx_pkg::sdhtx_axi_rsp_t      axi_rsp,
	input  wire logic                    trace_take,
	input  wire logic                    neg_just,
	input  wire logic                    pos_just,
	output sdhtx_pkg::sdhtx_ovh_t          ovh
);
	import sdhtx_pkg::*;

	typedef struct packed {
		logic                          aw_got;
		logic [AXI_AW-1:0]             aw_addr;
		logic                          w_got;
		logic [AXI_DW-1:0]             w_data;
		logic [3:0]                    w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [AXI_DW-1:0]             rdata;
		logic [1:0]                    rresp;
		logic [5:0][7:0]               nu;
		logic [7:0]                    k1;
		logic [7:0]                    k2;
		logic [7:0]                    s1;
		logic [1:0]                    ctl;
		logic [7:0]                    cfg30;
		logic [7:0]                    src61;
		logic [7:0]                    src62;
		logic                          adm;
		logic [PTR_W-1:0]              ptr;
		logic [TRACE_LEN-1:0][7:0]     mem;
		logic [CNT_W-1:0]              neg_cnt;
		logic [CNT_W-1:0]              pos_cnt;
		logic [CNT_W-1:0]              neg_buf;
		logic [CNT_W-1:0]              pos_buf;
		logic [7:0]                    trace_out;
	} sdhtx_state_t;

	sdhtx_state_t state_ff;
	sdhtx_state_t nxt_state;

	// Next pointer with wrap after the last string byte
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
		if (p == PTR_W'(TRACE_LEN - 1)) begin
			ptr_step = '0;
		end else begin
			ptr_step = p + PTR_W'(1);
		end
	endfunction : ptr_step

	// Word index of a byte address
	function automatic logic [IDX_W-1:0] to_idx(input logic [AXI_AW-1:0] a);
		to_idx = a[IDX_LSB +: IDX_W];
	endfunction : to_idx

	// Index belongs to the map
	function automatic logic is_mapped(input logic [IDX_W-1:0] i);
		is_mapped = (i == IDX_CFG_DEFAULTS) || (i == IDX_MODE) || (i == IDX_SRC_CFG3)
			|| (i == IDX_SRC_CFG2) || ((i >= IDX_NU_R1C8) && (i <= IDX_TRACE_DATA))
			|| (i == IDX_NEG_CAPTURE) || (i == IDX_POS_CAPTURE)
			|| (i == IDX_NEG_COUNT) || (i == IDX_POS_COUNT);
	endfunction : is_mapped

	logic                   aw_hs;
	logic                   w_hs;
	logic                   ar_hs;
	logic                   wr_fire;
	logic [AXI_AW-1:0]      wr_addr;
	logic [AXI_DW-1:0]      wr_data;
	logic [3:0]             wr_strb;
	logic [IDX_W-1:0]       wr_idx;
	logic [IDX_W-1:0]       rd_idx;
	logic                   wr_lo;
	logic                   neg_capture;
	logic                   pos_capture;
	logic                   data_wr;
	logic                   data_rd;
	logic                   clear_rise;
	logic [1:0]             new_ctl;
	logic [AXI_DW-1:0]      rd_word;

	// Handshake readiness: one transaction of each kind at a time
	assign aw_hs   = axi_req.awvalid && !state_ff.aw_got && !state_ff.bvalid;
	assign w_hs    = axi_req.wvalid && !state_ff.w_got && !state_ff.bvalid;
	assign ar_hs   = axi_req.arvalid && !state_ff.rvalid;
	assign wr_fire = (state_ff.aw_got || aw_hs) && (state_ff.w_got || w_hs) && !state_ff.bvalid;
	assign wr_addr = state_ff.aw_got ? state_ff.aw_addr : axi_req.awaddr;
	assign wr_data = state_ff.w_got ? state_ff.w_data : axi_req.wdata;
	assign wr_strb = state_ff.w_got ? state_ff.w_strb : axi_req.wstrb;
	assign wr_idx  = to_idx(wr_addr);
	assign rd_idx  = to_idx(axi_req.araddr);
	assign wr_lo   = wr_fire && wr_strb[0];

	// Access side effects
	assign neg_capture = wr_fire && (((wr_idx == IDX_NEG_COUNT) && wr_strb[1])
		|| ((wr_idx == IDX_NEG_CAPTURE) && wr_strb[0]));
	assign pos_capture = wr_fire && (((wr_idx == IDX_POS_COUNT) && wr_strb[1])
		|| ((wr_idx == IDX_POS_CAPTURE) && wr_strb[0]));
	assign data_wr    = wr_lo && (wr_idx == IDX_TRACE_DATA);
	assign data_rd    = ar_hs && (rd_idx == IDX_TRACE_DATA);
	assign new_ctl    = (wr_lo && (wr_idx == IDX_TRACE_CTL)) ? wr_data[1:0] : state_ff.ctl;
	assign clear_rise = new_ctl[CTL_CLEAR_BIT] && !state_ff.ctl[CTL_CLEAR_BIT];

	// Read multiplexer
	always_comb begin
		rd_word = '0;
		case (rd_idx)
			IDX_CFG_DEFAULTS: rd_word[7:0] = state_ff.cfg30;
			IDX_NU_R1C8:      rd_word[7:0] = state_ff.nu[0];
			IDX_NU_R1C9:      rd_word[7:0] = state_ff.nu[1];
			IDX_NU_R2C8:      rd_word[7:0] = state_ff.nu[2];
			IDX_NU_R2C9:      rd_word[7:0] = state_ff.nu[3];
			IDX_NU_R9C8:      rd_word[7:0] = state_ff.nu[4];
			IDX_NU_R9C9:      rd_word[7:0] = state_ff.nu[5];
			IDX_TX_K1:        rd_word[7:0] = state_ff.k1;
			IDX_TX_K2:        rd_word[7:0] = state_ff.k2;
			IDX_TX_S1:        rd_word[7:0] = state_ff.s1;
			IDX_TRACE_CTL:    rd_word[1:0] = state_ff.ctl;
			IDX_TRACE_DATA:   rd_word[7:0] = state_ff.mem[state_ff.ptr];
			IDX_MODE:         rd_word[MODE_ADM_BIT] = state_ff.adm;
			IDX_SRC_CFG3:     rd_word[7:0] = state_ff.src61;
			IDX_SRC_CFG2:     rd_word[7:0] = state_ff.src62;
			IDX_NEG_COUNT:    rd_word[CNT_W-1:0] = state_ff.neg_buf;
			IDX_POS_COUNT:    rd_word[CNT_W-1:0] = state_ff.pos_buf;
			default:          rd_word = '0;
		endcase
	end

	// Next state
	always_comb begin
		nxt_state = state_ff;
		// Write address and data capture, response
		if (aw_hs && !wr_fire) begin
			nxt_state.aw_got  = 1'b1;
			nxt_state.aw_addr = axi_req.awaddr;
		end
		if (w_hs && !wr_fire) begin
			nxt_state.w_got  = 1'b1;
			nxt_state.w_data = axi_req.wdata;
			nxt_state.w_strb = axi_req.wstrb;
		end
		if (wr_fire) begin
			nxt_state.aw_got = 1'b0;
			nxt_state.w_got  = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp  = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (state_ff.bvalid && axi_req.bready) begin
			nxt_state.bvalid = 1'b0;
		end
		// Read answer one cycle after the address
		if (ar_hs) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata  = rd_word;
			nxt_state.rresp  = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (state_ff.rvalid && axi_req.rready) begin
			nxt_state.rvalid = 1'b0;
		end
		// Byte registers
		if (wr_lo) begin
			case (wr_idx)
				IDX_CFG_DEFAULTS: nxt_state.cfg30 = wr_data[7:0];
				IDX_NU_R1C8:      nxt_state.nu[0] = wr_data[7:0];
				IDX_NU_R1C9:      nxt_state.nu[1] = wr_data[7:0];
				IDX_NU_R2C8:      nxt_state.nu[2] = wr_data[7:0];
				IDX_NU_R2C9:      nxt_state.nu[3] = wr_data[7:0];
				IDX_NU_R9C8:      nxt_state.nu[4] = wr_data[7:0];
				IDX_NU_R9C9:      nxt_state.nu[5] = wr_data[7:0];
				IDX_TX_K1:        nxt_state.k1 = wr_data[7:0];
				IDX_TX_K2:        nxt_state.k2 = wr_data[7:0];
				IDX_TX_S1:        nxt_state.s1 = wr_data[7:0];
				IDX_MODE:         nxt_state.adm = wr_data[MODE_ADM_BIT];
				IDX_SRC_CFG3:     nxt_state.src61 = wr_data[7:0];
				IDX_SRC_CFG2:     nxt_state.src62 = wr_data[7:0];
				default:          nxt_state.cfg30 = nxt_state.cfg30;
			endcase
		end
		nxt_state.ctl = new_ctl;
		// Trace string store and pointer; clear beats advance
		if (data_wr) begin
			nxt_state.mem[state_ff.ptr] = wr_data[7:0];
		end
		if (clear_rise) begin
			nxt_state.ptr = '0;
		end else if (state_ff.ctl[CTL_PROC_BIT]) begin
			if (data_wr && data_rd) begin
				nxt_state.ptr = ptr_step(ptr_step(state_ff.ptr));
			end else if (data_wr || data_rd) begin
				nxt_state.ptr = ptr_step(state_ff.ptr);
			end
		end else if (trace_take) begin
			nxt_state.ptr = ptr_step(state_ff.ptr);
		end
		// Justification counters; a capture keeps a same-cycle event
		if (neg_capture) begin
			nxt_state.neg_buf = state_ff.neg_cnt;
			nxt_state.neg_cnt = CNT_W'(neg_just && state_ff.adm);
		end else if (neg_just && state_ff.adm) begin
			nxt_state.neg_cnt = state_ff.neg_cnt + CNT_W'(1);
		end
		if (pos_capture) begin
			nxt_state.pos_buf = state_ff.pos_cnt;
			nxt_state.pos_cnt = CNT_W'(pos_just && state_ff.adm);
		end else if (pos_just && state_ff.adm) begin
			nxt_state.pos_cnt = state_ff.pos_cnt + CNT_W'(1);
		end
		// Outgoing trace byte follows the pointer, fill byte under processor control
		nxt_state.trace_out = nxt_state.ctl[CTL_PROC_BIT] ? TRACE_FILL
			: nxt_state.mem[nxt_state.ptr];
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Bus answers
	assign axi_rsp.awready = !state_ff.aw_got && !state_ff.bvalid;
	assign axi_rsp.wready  = !state_ff.w_got && !state_ff.bvalid;
	assign axi_rsp.bvalid  = state_ff.bvalid;
	assign axi_rsp.bresp   = state_ff.bresp;
	assign axi_rsp.arready = !state_ff.rvalid;
	assign axi_rsp.rvalid  = state_ff.rvalid;
	assign axi_rsp.rdata   = state_ff.rdata;
	assign axi_rsp.rresp   = state_ff.rresp;

	// Source selection towards frame assembly
	assign ovh.national_byte = state_ff.nu;
	assign ovh.national_use[0] = (state_ff.src62[SRC2_R1C8_LSB +: 2] == SRC_PROCESSOR)
		&& !state_ff.cfg30[CFG_R1_DEF_BIT];
	assign ovh.national_use[1] = (state_ff.src62[SRC2_R1C9_LSB +: 2] == SRC_PROCESSOR)
		&& !state_ff.cfg30[CFG_R1_DEF_BIT];
	assign ovh.national_use[2] = state_ff.src62[SRC2_R2C8_LSB +: 2] == SRC_PROCESSOR;
	assign ovh.national_use[3] = state_ff.src62[SRC2_R2C9_LSB +: 2] == SRC_PROCESSOR;
	assign ovh.national_use[4] = !state_ff.src61[SRC3_R9C8_BIT];
	assign ovh.national_use[5] = !state_ff.src61[SRC3_R9C9_BIT];
	assign ovh.aps1_use        = !state_ff.src61[SRC3_K1_BIT];
	assign ovh.aps1_byte_value = state_ff.k1;
	assign ovh.aps2_use        = !state_ff.src61[SRC3_K2_BIT]
		&& state_ff.cfg30[CFG_K2_RDI_BIT];
	assign ovh.aps2_byte_value = state_ff.k2;
	assign ovh.sync_status_use        = !state_ff.src61[SRC3_S1_BIT];
	assign ovh.sync_status_byte_value = state_ff.s1;
	assign ovh.trace_tx_byte          = state_ff.trace_out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Step sequences of pointer movement and selection register writes
	sequence s_hw_take;
		!state_ff.ctl[CTL_PROC_BIT] && !clear_rise && trace_take;
	endsequence
	sequence s_proc_access;
		state_ff.ctl[CTL_PROC_BIT] && !clear_rise && (data_wr != data_rd);
	endsequence

	sequence s_proc_idle;
		state_ff.ctl[CTL_PROC_BIT] && !clear_rise && !data_wr && !data_rd && trace_take;
	endsequence
	sequence s_src3_write;
		wr_lo && (wr_idx == IDX_SRC_CFG3);
	endsequence
	sequence s_src2_write;
		wr_lo && (wr_idx == IDX_SRC_CFG2);
	endsequence

	// Pointer movement
	a_ptr_hw_step: assert property (
		s_hw_take |=> state_ff.ptr == ptr_step($past(state_ff.ptr)))
		else $error("pointer did not follow insertion");
	a_ptr_proc_step: assert property (
		s_proc_access |=> state_ff.ptr == ptr_step($past(state_ff.ptr)))
		else $error("pointer did not follow access");
	a_take_ignored: assert property (
		s_proc_idle |=> $stable(state_ff.ptr))
		else $error("insertion moved pointer under processor control");
	a_ptr_clear: assert property (
		clear_rise |=> state_ff.ptr == '0)
		else $error("pointer not cleared on rising clear bit");
	a_ptr_steady: assert property (
		!clear_rise && !trace_take && !data_wr && !data_rd |=> $stable(state_ff.ptr))
		else $error("pointer moved without cause");
	a_ptr_wrap: assert property (
		s_hw_take ##0 (state_ff.ptr == PTR_W'(TRACE_LEN - 1)) |=> state_ff.ptr == '0)
		else $error("pointer did not wrap");
	// String store and outgoing byte
	a_data_store: assert property (
		data_wr |=> state_ff.mem[$past(state_ff.ptr)] == 8'($past(wr_data)))
		else $error("string byte not stored at pointer");
	a_data_read: assert property (
		data_rd && !data_wr |=> axi_rsp.rdata[7:0] == state_ff.mem[$past(state_ff.ptr)])
		else $error("string byte not read at pointer");
	a_fill_sent: assert property (
		state_ff.ctl[CTL_PROC_BIT] |-> ovh.trace_tx_byte == TRACE_FILL)
		else $error("fill byte not sent under processor control");
	a_byte_follows: assert property (
		!state_ff.ctl[CTL_PROC_BIT] |-> ovh.trace_tx_byte == state_ff.mem[state_ff.ptr])
		else $error("outgoing byte not at pointer");
	// Justification counters and capture buffers
	a_cnt_hold: assert property (
		!state_ff.adm && !neg_capture |=> $stable(state_ff.neg_cnt))
		else $error("counter moved outside add-drop mode");
	a_pos_hold: assert property (
		!state_ff.adm && !pos_capture |=> $stable(state_ff.pos_cnt))
		else $error("positive counter moved outside add-drop mode");
	a_neg_count: assert property (
		state_ff.adm && neg_just && !neg_capture
		|=> state_ff.neg_cnt == $past(state_ff.neg_cnt) + CNT_W'(1))
		else $error("negative count missed event");
	a_pos_count: assert property (
		state_ff.adm && pos_just && !pos_capture
		|=> state_ff.pos_cnt == $past(state_ff.pos_cnt) + CNT_W'(1))
		else $error("positive count missed event");
	a_neg_capture: assert property (
		neg_capture && !neg_just |=>
		state_ff.neg_buf == $past(state_ff.neg_cnt) && state_ff.neg_cnt == '0)
		else $error("negative capture failed");
	a_pos_capture: assert property (
		pos_capture && !pos_just |=>
		state_ff.pos_buf == $past(state_ff.pos_cnt) && state_ff.pos_cnt == '0)
		else $error("positive capture failed");
	a_neg_buf_hold: assert property (
		!neg_capture |=> $stable(state_ff.neg_buf))
		else $error("negative buffer changed without capture");
	a_pos_buf_hold: assert property (
		!pos_capture |=> $stable(state_ff.pos_buf))
		else $error("positive buffer changed without capture");
	// Source selection after a write of the selection registers
	a_k1_select: assert property (
		s_src3_write ##0 !wr_data[SRC3_K1_BIT] |=> ovh.aps1_use)
		else $error("K1 not taken from register");
	a_k2_select: assert property (
		s_src3_write ##0 (wr_data[SRC3_K2_BIT] || !state_ff.cfg30[CFG_K2_RDI_BIT])
		|=> !ovh.aps2_use)
		else $error("K2 selection wrong");
	a_s1_select: assert property (
		s_src3_write ##0 !wr_data[SRC3_S1_BIT] |=> ovh.sync_status_use)
		else $error("S1 not taken from register");
	a_r2_select: assert property (
		s_src2_write ##0 (wr_data[SRC2_R2C8_LSB +: 2] == SRC_PROCESSOR) |=> ovh.national_use[2])
		else $error("r2c8 byte not taken from register");
	a_r1_default: assert property (
		state_ff.cfg30[CFG_R1_DEF_BIT] |-> !ovh.national_use[0] && !ovh.national_use[1])
		else $error("row 1 byte taken while default enabled");
	// Bus answers one cycle after the request is complete
	a_read_answer: assert property (
		ar_hs |=> axi_rsp.rvalid [*1] ##0 !axi_rsp.arready)
		else $error("read not answered next cycle");
	a_write_answer: assert property (
		wr_fire |=> axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready)
		else $error("write not answered next cycle");
endmodule : sdhtx_overhead_regs

// ==== inc/sdhtx_pkg.sv ====
package sdhtx_pkg;
	// Bus geometry
	localparam int AXI_AW   = 12;
	localparam int AXI_DW   = 32;
	localparam int IDX_LSB  = 2;
	localparam int IDX_W    = 8;
	// Register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CFG_DEFAULTS   = 8'h30;
	localparam logic [IDX_W-1:0] IDX_NU_R1C8        = 8'h31;
	localparam logic [IDX_W-1:0] IDX_NU_R1C9        = 8'h32;
	localparam logic [IDX_W-1:0] IDX_NU_R2C8        = 8'h33;
	localparam logic [IDX_W-1:0] IDX_NU_R2C9        = 8'h34;
	localparam logic [IDX_W-1:0] IDX_NU_R9C8        = 8'h35;
	localparam logic [IDX_W-1:0] IDX_NU_R9C9        = 8'h36;
	localparam logic [IDX_W-1:0] IDX_TX_K1          = 8'h37;
	localparam logic [IDX_W-1:0] IDX_TX_K2          = 8'h38;
	localparam logic [IDX_W-1:0] IDX_TX_S1          = 8'h39;
	localparam logic [IDX_W-1:0] IDX_TRACE_CTL      = 8'h3a;
	localparam logic [IDX_W-1:0] IDX_TRACE_DATA     = 8'h3b;
	localparam logic [IDX_W-1:0] IDX_MODE           = 8'h40;
	localparam logic [IDX_W-1:0] IDX_SRC_CFG3       = 8'h61;
	localparam logic [IDX_W-1:0] IDX_SRC_CFG2       = 8'h62;
	localparam logic [IDX_W-1:0] IDX_NEG_CAPTURE    = 8'h92;
	localparam logic [IDX_W-1:0] IDX_POS_CAPTURE    = 8'h94;
	localparam logic [IDX_W-1:0] IDX_NEG_COUNT      = 8'he2;
	localparam logic [IDX_W-1:0] IDX_POS_COUNT      = 8'he4;
	// Field positions
	localparam int CTL_CLEAR_BIT    = 0;
	localparam int CTL_PROC_BIT     = 1;
	localparam int CFG_K2_RDI_BIT   = 4;
	localparam int CFG_R1_DEF_BIT   = 5;
	localparam int SRC3_K1_BIT      = 0;
	localparam int SRC3_K2_BIT      = 1;
	localparam int SRC3_S1_BIT      = 2;
	localparam int SRC3_R9C8_BIT    = 6;
	localparam int SRC3_R9C9_BIT    = 7;
	localparam int SRC2_R1C8_LSB    = 0;
	localparam int SRC2_R1C9_LSB    = 2;
	localparam int SRC2_R2C8_LSB    = 4;
	localparam int SRC2_R2C9_LSB    = 6;
	localparam int MODE_ADM_BIT     = 0;
	// Widths and values
	localparam int CNT_W            = 11;
	localparam int TRACE_LEN        = 16;
	localparam int PTR_W            = 4;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [7:0] TRACE_FILL     = 8'h01;
	localparam logic [1:0] SRC_PROCESSOR  = 2'b00;
	localparam logic [1:0] RESP_OKAY      = 2'b00;
	localparam logic [1:0] RESP_SLVERR    = 2'b10;
	// Master to slave
	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} sdhtx_axi_req_t;
	// Slave to master
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0]        rresp;
	} sdhtx_axi_rsp_t;
	// Overhead bytes offered to frame assembly, each but the trace byte with its use flag
	typedef struct packed {
		logic [5:0]      national_use;
		logic [5:0][7:0] national_byte;
		logic            aps1_use;
		logic [7:0]      aps1_byte_value;
		logic            aps2_use;
		logic [7:0]      aps2_byte_value;
		logic            sync_status_use;
		logic [7:0]      sync_status_byte_value;
		logic [7:0]      trace_tx_byte;
	} sdhtx_ovh_t;
endpackage : sdhtx_pkg

// ==== test/test_sdh_tx_overhead_byte_regs.sv ====
`timescale 1ns/1ps
module test_sdh_tx_overhead_byte_regs;
	import sdhtx_pkg::*;
	logic           clk;
	logic           rst_n;
	logic           trace_take;
	logic           neg_just;
	logic           pos_just;
	sdhtx_axi_req_t req;
	sdhtx_axi_rsp_t rsp;
	sdhtx_ovh_t     ovh;
	int             fail_count;
	int             tests_run;
	int             cycles;
	int             n;
	int             m;
	logic [1:0]     resp;
	logic [31:0]    rd;
	logic [7:0]     str [TRACE_LEN];
	logic [7:0]     byt [9];
	logic [7:0]     cfg;
	logic [7:0]     s61;
	logic [7:0]     s62;

	sdhtx_overhead_regs i_dut (
		.clk        (clk),
		.rst_n      (rst_n),
		.axi_req    (req),
		.axi_rsp    (rsp),
		.trace_take (trace_take),
		.neg_just   (neg_just),
		.pos_just   (pos_just),
		.ovh        (ovh)
	);

	// Free running clock
	always #25 clk = ~clk;

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ba

	// Expected use flags: six national, K1, K2, S1
	function automatic logic [8:0] exp_use(input logic [7:0] c, input logic [7:0] a,
			input logic [7:0] b);
		logic [5:0] nu;
		nu[0] = (b[1:0] == SRC_PROCESSOR) && !c[CFG_R1_DEF_BIT];
		nu[1] = (b[3:2] == SRC_PROCESSOR) && !c[CFG_R1_DEF_BIT];
		nu[2] = (b[5:4] == SRC_PROCESSOR);
		nu[3] = (b[7:6] == SRC_PROCESSOR);
		nu[4] = !a[SRC3_R9C8_BIT];
		nu[5] = !a[SRC3_R9C9_BIT];
		return {nu, !a[SRC3_K1_BIT], !a[SRC3_K2_BIT] && c[CFG_K2_RDI_BIT], !a[SRC3_S1_BIT]};
	endfunction : exp_use

	// Write: offer both channels, release each when taken, wait for response
	task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_done;
		logic w_done;
		logic a_take;
		logic w_take;
		aw_done = 1'b0;
		w_done = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= s;
		while (!(aw_done && w_done)) begin
			@(negedge clk);
			a_take = !aw_done && (rsp.awready === 1'b1);
			w_take = !w_done && (rsp.wready === 1'b1);
			@(posedge clk);
			if (a_take) begin
				aw_done = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (w_take) begin
				w_done = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(negedge clk); while (rsp.bvalid !== 1'b1);
		resp = rsp.bresp;
		@(posedge clk);
	endtask : axi_wr

	// Read: address until taken, then wait for data
	task axi_rd(input logic [11:0] a);
		logic taken;
		taken = 1'b0;
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		while (!taken) begin
			@(negedge clk);
			taken = (rsp.arready === 1'b1);
			@(posedge clk);
		end
		req.arvalid <= 1'b0;
		do @(negedge clk); while (rsp.rvalid !== 1'b1);
		rd = rsp.rdata;
		resp = rsp.rresp;
		@(posedge clk);
	endtask : axi_rd

	task wr8(input logic [7:0] idx, input logic [7:0] v);
		axi_wr(ba(idx), {24'h00_0000, v}, 4'b0001);
	endtask : wr8

	// Back to back justification events, one per cycle
	task events(input int cnt, input logic neg);
		if (cnt > 0) begin
			if (neg)
				neg_just <= 1'b1;
			else
				pos_just <= 1'b1;
			repeat (cnt) @(posedge clk);
			neg_just <= 1'b0;
			pos_just <= 1'b0;
		end
		@(posedge clk);
	endtask : events

	task take_byte;
		trace_take <= 1'b1;
		@(posedge clk);
		trace_take <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : take_byte

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		trace_take = 1'b0;
		neg_just = 1'b0;
		pos_just = 1'b0;
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		void'($urandom(47));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values and default source flags
		for (int i = 0; i < 11; i++) begin
			axi_rd(ba(8'(IDX_NU_R1C8 + i)));
			check(rd, 32'h0000_0000, "reset value");
		end
		check(32'({ovh.national_use, ovh.aps1_use, ovh.aps2_use, ovh.sync_status_use}),
			32'h0000_01fd, "reset use flags");
		// Processor supplied bytes under corner and random source settings
		for (int k = 0; k < 6; k++) begin
			for (int i = 0; i < 9; i++) begin
				byt[i] = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
				wr8(8'(IDX_NU_R1C8 + i), byt[i]);
			end
			cfg = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			s61 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			s62 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			wr8(IDX_CFG_DEFAULTS, cfg);
			wr8(IDX_SRC_CFG3, s61);
			wr8(IDX_SRC_CFG2, s62);
			repeat (3) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				axi_rd(ba(8'(IDX_NU_R1C8 + i)));
				check(rd, 32'(byt[i]), "byte readback");
			end
			for (int i = 0; i < 6; i++) begin
				check(32'(ovh.national_byte[i]), 32'(byt[i]), "national byte");
			end
			check(32'(ovh.aps1_byte_value), 32'(byt[6]), "aps1 byte");
			check(32'(ovh.aps2_byte_value), 32'(byt[7]), "aps2 byte");
			check(32'(ovh.sync_status_byte_value), 32'(byt[8]), "sync byte");
			check(32'({ovh.national_use, ovh.aps1_use, ovh.aps2_use, ovh.sync_status_use}),
				32'(exp_use(cfg, s61, s62)), "use flags");
		end
		// Unmapped place is refused
		wr8(8'h50, 8'h5a);
		check(32'(resp), 32'(RESP_SLVERR), "unmapped write");
		axi_rd(ba(8'h50));
		check(32'({rd, resp}), 32'(RESP_SLVERR), "unmapped read");
		// Processor controlled string: fill, wrap, read back
		wr8(IDX_TRACE_CTL, 8'h00);
		wr8(IDX_TRACE_CTL, 8'h01);
		wr8(IDX_TRACE_CTL, 8'h02);
		for (int i = 0; i < TRACE_LEN; i++) begin
			str[i] = 8'($urandom);
			wr8(IDX_TRACE_DATA, str[i]);
		end
		repeat (3) @(posedge clk);
		check(32'(ovh.trace_tx_byte), 32'(TRACE_FILL), "fill while processor owns");
		take_byte();
		for (int i = 0; i < TRACE_LEN; i++) begin
			axi_rd(ba(IDX_TRACE_DATA));
			check(rd, 32'(str[i]), "string readback");
		end
		// Clear only on a rising edge of the clear bit
		wr8(IDX_TRACE_CTL, 8'h03);
		axi_rd(ba(IDX_TRACE_DATA));
		check(rd, 32'(str[0]), "clear on rise");
		wr8(IDX_TRACE_CTL, 8'h03);
		axi_rd(ba(IDX_TRACE_DATA));
		check(rd, 32'(str[1]), "steady bit keeps pointer");
		wr8(IDX_TRACE_CTL, 8'h02);
		wr8(IDX_TRACE_CTL, 8'h03);
		axi_rd(ba(IDX_TRACE_DATA));
		check(rd, 32'(str[0]), "second rise clears");
		// Frame insertion walks the string and wraps
		wr8(IDX_TRACE_CTL, 8'h00);
		wr8(IDX_TRACE_CTL, 8'h01);
		repeat (3) @(posedge clk);
		check(32'(ovh.trace_tx_byte), 32'(str[0]), "first string byte");
		for (int i = 1; i <= TRACE_LEN; i++) begin
			take_byte();
			check(32'(ovh.trace_tx_byte), 32'(str[i % TRACE_LEN]), "inserted byte");
		end
		// Counters hold outside add-drop mode
		events(5, 1'b1);
		events(5, 1'b0);
		axi_wr(ba(IDX_NEG_CAPTURE), 32'h0000_0000, 4'b0001);
		axi_wr(ba(IDX_POS_COUNT), 32'h0000_0000, 4'b0010);
		axi_rd(ba(IDX_NEG_COUNT));
		check(rd, 32'h0000_0000, "negative held");
		axi_rd(ba(IDX_POS_COUNT));
		check(rd, 32'h0000_0000, "positive held");
		// Add-drop mode: count, capture, clear
		wr8(IDX_MODE, 8'h01);
		for (int r = 0; r < 4; r++) begin
			n = (r == 3) ? 0 : int'($urandom_range(1, 40));
			m = int'($urandom_range(1, 40));
			events(n, 1'b1);
			events(m, 1'b0);
			axi_wr(ba(r[0] ? IDX_NEG_CAPTURE : IDX_NEG_COUNT), 32'h0000_ffff,
				r[0] ? 4'b0001 : 4'b0010);
			axi_wr(ba(r[0] ? IDX_POS_COUNT : IDX_POS_CAPTURE), 32'h0000_ffff,
				r[0] ? 4'b0010 : 4'b0001);
			axi_rd(ba(IDX_NEG_COUNT));
			check(rd, 32'(n), "negative capture");
			axi_rd(ba(IDX_POS_COUNT));
			check(rd, 32'(m), "positive capture");
		end
		finish_test();
	end
endmodule : test_sdh_tx_overhead_byte_regs
